// File: hw/rfc_consts.svh
// Constants for the serial-bus register target.
// Assumes inclusion by the design module rfc_top by bare name.
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH
`define RFC_DEV_ADDR 7'h37
`define RFC_REG_COUNT 4
`define RFC_REG_R0_IDX 2'h0
`define RFC_REG_R1_IDX 2'h1
`define RFC_REG_FLASH_IDX 2'h2
`define RFC_REG_VREG_IDX 2'h3
`define RFC_R0_RESET 8'h00
`define RFC_R1_RESET 8'h00
`define RFC_FLASH_RESET 8'h10
`define RFC_VREG_RESET 8'h00
`define RFC_FLASH_RSVD_MASK 8'h1f
`define RFC_VREG_RSVD_MASK 8'h7f
`define RFC_FLASH_RANGE_BIT 0
`define RFC_FLASH_LEVEL_LSB 1
`define RFC_FLASH_TMO_BIT 4
`define RFC_REG1_LSB 0
`define RFC_REG2_LSB 4
`define RFC_REG1_MAX_CODE 4'h9
`define RFC_REG2_MAX_CODE 3'h4
`define RFC_FLASH_MAX_MS 500
`define RFC_CLK_MHZ 50
`define RFC_FLASH_MAX_CYC (`RFC_FLASH_MAX_MS * 1000 * `RFC_CLK_MHZ)
`endif

// File: hw/rfc_pkg.sv
// Types for the serial-bus register target.
// Assumes no surroundings beyond the constants header.
package rfc_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_AACK = 7'b0000100,
        ST_WBYT = 7'b0001000,
        ST_WACK = 7'b0010000,
        ST_RBYT = 7'b0100000,
        ST_RACK = 7'b1000000
    } rfc_state_t;
    typedef logic [7:0] rfc_byte_t;
endpackage

// File: hw/rfc_sync.sv
// Two-stage synchroniser with start and stop detection for the bus pins.
// Assumes pins asynchronous to CLK_SYS_IN.
`timescale 1ns/1ps
`default_nettype none
module rfc_sync (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic scl_pin_in,
    input wire logic sda_pin_in,
    output logic scl_out,
    output logic sda_out,
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_out,
    output logic stop_out
);
    logic [1:0] scl_ff_reg;
    logic [1:0] sda_ff_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            scl_ff_reg <= 2'h3;
            sda_ff_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_ff_reg <= {scl_ff_reg[0], scl_pin_in};
            sda_ff_reg <= {sda_ff_reg[0], sda_pin_in};
            scl_d_reg <= scl_ff_reg[1];
            sda_d_reg <= sda_ff_reg[1];
        end
    end
    assign scl_out = scl_ff_reg[1];
    assign sda_out = sda_ff_reg[1];
    assign scl_rise_out = scl_ff_reg[1] & ~scl_d_reg;
    assign scl_fall_out = ~scl_ff_reg[1] & scl_d_reg;
    assign start_out = scl_ff_reg[1] & scl_d_reg & sda_d_reg & ~sda_ff_reg[1];
    assign stop_out = scl_ff_reg[1] & scl_d_reg & ~sda_d_reg & sda_ff_reg[1];
endmodule // rfc_sync
`default_nettype wire

// File: hw/rfc_top.sv
// Serial-bus register target with flash range and regulator control.
// Assumes an external master on open-drain lines; SCL/SDA may be asynchronous.
//
// Behaviour
// - Range bit one selects high flash range
// - Range bit zero selects spotlight range
// - Register three enables and sets both regulators
// - Second regulator code table, high codes off
// - First regulator code table 3.3V to 2.5V
// - Four readable writable eight-bit registers
// - No pointer increment; one register each
// - Start, stop frame; repeated start accepted
// - Only seven-bit addressing decoded
// - Works at standard and fast rates
// - Answers address 0x37, bytes 0x6E/0x6F
// - Eighth address bit gives direction
// - Write: address, register, data, all acknowledged
// - Combined read returns pointed register byte
// - Pointer kept across stop and others
// - Later read returns previously pointed register
// - Enable low resets all registers
// - Registers kept during thermal shutdown
`timescale 1ns/1ps
`default_nettype none
`include "rfc_consts.svh"
module rfc_top #(
    parameter int FLASH_MAX_CYC = `RFC_FLASH_MAX_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    // Device enable and thermal state
    input wire logic ENABLE_PIN_IN,
    input wire logic THERMAL_SHDN_IN,
    // Serial bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // Flash sink
    output logic FLASH_RANGE_HIGH_OUT,
    output logic [2:0] FLASH_LEVEL_OUT,
    output logic FLASH_TMO_EN_OUT,
    output logic FLASH_PULSE_LIMIT_OUT,
    // Regulators
    output logic REG1_ON_OUT,
    output logic [3:0] REG1_CODE_OUT,
    output logic REG2_ON_OUT,
    output logic [2:0] REG2_CODE_OUT
);
    import rfc_pkg::*;

    initial begin
        if (FLASH_MAX_CYC < 1) $error("FLASH_MAX_CYC must be positive");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
    logic [1:0] en_ff_reg;
    logic dev_rst;
    rfc_sync u_sync (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .scl_pin_in(SCL_IN),
        .sda_pin_in(SDA_IN),
        .scl_out(scl_s),
        .sda_out(sda_s),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(bus_start),
        .stop_out(bus_stop)
    );
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) en_ff_reg <= 2'h0;
        else en_ff_reg <= {en_ff_reg[0], ENABLE_PIN_IN};
    end
    assign dev_rst = SRST_IN | ~en_ff_reg[1];

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    rfc_state_t state_reg;
    rfc_byte_t shift_reg;
    logic [3:0] bit_cnt_reg;
    logic rd_dir_reg;
    logic ptr_phase_reg;
    logic [1:0] ptr_reg;
    logic [7:0] regs_reg [`RFC_REG_COUNT];
    logic wr_stb;
    logic sda_drv_reg;
    logic match;

    function automatic logic [1:0] rfc_idx(input rfc_byte_t b);
        rfc_idx = b[1:0];
    endfunction

    function automatic rfc_byte_t rfc_mask(input logic [1:0] idx, input rfc_byte_t d);
        if (idx == `RFC_REG_FLASH_IDX) rfc_mask = d & `RFC_FLASH_RSVD_MASK;
        else if (idx == `RFC_REG_VREG_IDX) rfc_mask = d & `RFC_VREG_RSVD_MASK;
        else rfc_mask = d;
    endfunction

    // Only 7-bit addresses; 10-bit prefix 11110xx never matches 0x37
    assign match = (shift_reg[7:1] == `RFC_DEV_ADDR);

    always_ff @(posedge CLK_SYS_IN) begin
        if (dev_rst) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            rd_dir_reg <= 1'b0;
            ptr_phase_reg <= 1'b0;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
        end else if (bus_start) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WBYT: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_WBYT) begin
                            state_reg <= ST_WACK;
                        end else if (match) begin
                            rd_dir_reg <= shift_reg[0];
                            ptr_phase_reg <= 1'b1;
                            state_reg <= ST_AACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (rd_dir_reg) begin
                            shift_reg <= regs_reg[ptr_reg];
                            state_reg <= ST_RBYT;
                        end else begin
                            state_reg <= ST_WBYT;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        ptr_phase_reg <= 1'b0;
                        state_reg <= ptr_phase_reg ? ST_WBYT : ST_IDLE;
                    end
                end
                ST_RBYT: begin
                    if (scl_fall) begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7) state_reg <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    // Acknowledge bit ends the read, ACK or NACK; no second byte
                    if (scl_fall) state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign wr_stb = (state_reg == ST_WBYT) && scl_fall && (bit_cnt_reg == 4'h8) && !bus_stop
        && !bus_start;

    // ----------------------------------------
    // Pointer and registers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (dev_rst) ptr_reg <= `RFC_REG_R0_IDX;
        else if (wr_stb && ptr_phase_reg) ptr_reg <= rfc_idx(shift_reg);
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (dev_rst) begin
            regs_reg[`RFC_REG_R0_IDX] <= `RFC_R0_RESET;
            regs_reg[`RFC_REG_R1_IDX] <= `RFC_R1_RESET;
            regs_reg[`RFC_REG_FLASH_IDX] <= `RFC_FLASH_RESET;
            regs_reg[`RFC_REG_VREG_IDX] <= `RFC_VREG_RESET;
        end else if (wr_stb && !ptr_phase_reg) begin
            // Thermal shutdown does not touch stored values
            regs_reg[ptr_reg] <= rfc_mask(ptr_reg, shift_reg);
        end
    end

    // ----------------------------------------
    // SDA drive
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (dev_rst) sda_drv_reg <= 1'b0;
        else if (state_reg == ST_AACK || state_reg == ST_WACK) sda_drv_reg <= 1'b1;
        else if (state_reg == ST_RBYT) sda_drv_reg <= ~shift_reg[7];
        else sda_drv_reg <= 1'b0;
    end
    always_ff @(posedge CLK_SYS_IN) begin
        SDA_OUT <= 1'b0;
        if (SRST_IN) SDA_OE_OUT <= 1'b0;
        else SDA_OE_OUT <= sda_drv_reg & ~bus_stop & ~bus_start;
    end

    // ----------------------------------------
    // Flash and regulator outputs
    // ----------------------------------------
    logic [31:0] pulse_cnt_reg;
    logic flash_on;
    rfc_byte_t fl_r, vr_r;
    assign fl_r = regs_reg[`RFC_REG_FLASH_IDX];
    assign vr_r = regs_reg[`RFC_REG_VREG_IDX];
    assign flash_on = fl_r[`RFC_FLASH_RANGE_BIT] && (fl_r[3:1] != 3'h0) && !THERMAL_SHDN_IN;

    always_ff @(posedge CLK_SYS_IN) begin
        if (dev_rst || !flash_on) pulse_cnt_reg <= 32'h0;
        else if (pulse_cnt_reg < FLASH_MAX_CYC) pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (dev_rst) begin
            FLASH_RANGE_HIGH_OUT <= 1'b0;
            FLASH_LEVEL_OUT <= 3'h0;
            FLASH_TMO_EN_OUT <= 1'b1;
            FLASH_PULSE_LIMIT_OUT <= 1'b0;
            REG1_ON_OUT <= 1'b0;
            REG1_CODE_OUT <= 4'h0;
            REG2_ON_OUT <= 1'b0;
            REG2_CODE_OUT <= 3'h0;
        end else begin
            FLASH_RANGE_HIGH_OUT <= fl_r[`RFC_FLASH_RANGE_BIT];
            FLASH_LEVEL_OUT <= THERMAL_SHDN_IN ? 3'h0 : fl_r[3:1];
            FLASH_TMO_EN_OUT <= fl_r[`RFC_FLASH_TMO_BIT];
            FLASH_PULSE_LIMIT_OUT <= flash_on && (pulse_cnt_reg >= FLASH_MAX_CYC);
            REG1_ON_OUT <= !THERMAL_SHDN_IN && vr_r[3:0] != 4'h0
                && vr_r[3:0] <= `RFC_REG1_MAX_CODE;
            REG1_CODE_OUT <= vr_r[3:0];
            REG2_ON_OUT <= !THERMAL_SHDN_IN && vr_r[6:4] != 3'h0
                && vr_r[6:4] <= `RFC_REG2_MAX_CODE;
            REG2_CODE_OUT <= vr_r[6:4];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence addr_ack_s;
        state_reg == ST_AACK;
    endsequence
    ack_drive_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        addr_ack_s ##1 (state_reg == ST_AACK) |=> SDA_OE_OUT || bus_stop || bus_start)
        else $error("ack not driven");
    reg1_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        (vr_r[3:0] > 4'h9) |=> !REG1_ON_OUT) else $error("reg1 on with bad code");
    reg2_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        (vr_r[6:4] > 3'h4) |=> !REG2_ON_OUT) else $error("reg2 on with bad code");
    range_follow_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        ##1 FLASH_RANGE_HIGH_OUT == $past(fl_r[0])) else $error("range mismatch");
    ptr_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        !(wr_stb && ptr_phase_reg) |=> $stable(ptr_reg)) else $error("pointer moved");
    rst_val_a: assert property (@(posedge CLK_SYS_IN)
        dev_rst |=> regs_reg[`RFC_REG_FLASH_IDX] == `RFC_FLASH_RESET)
        else $error("reset value wrong");
    rsvd_zero_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        !vr_r[7] && fl_r[7:5] == 3'h0) else $error("reserved bit set");
    stop_idle_a: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
        bus_stop |=> state_reg == ST_IDLE) else $error("stop ignored");
endmodule // rfc_top
`default_nettype wire

// File: test/rfc_master_model.sv
// Serial bus master model: drives SCL and pulls SDA low, open drain.
// Assumes a pull-up on SDA and the bench clock on clk_in.
`timescale 1ns/1ps
`default_nettype none
module rfc_master_model (
    // Clock
    input wire logic clk_in,
    // Bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    int quarter = 31;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic tick();
        repeat (quarter) @(negedge clk_in);
    endtask
    // ----------------------------------------
    // Framing
    // ----------------------------------------
    task automatic start();
        sda_low_out = 1'b0;
        tick();
        scl_out = 1'b1;
        tick();
        sda_low_out = 1'b1;
        tick();
        scl_out = 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        tick();
        scl_out = 1'b1;
        tick();
        sda_low_out = 1'b0;
        tick();
    endtask
    // ----------------------------------------
    // Bits and bytes, MSB first
    // ----------------------------------------
    task automatic bitx(input logic b, output logic r);
        sda_low_out = ~b;
        tick();
        scl_out = 1'b1;
        tick();
        r = sda_in;
        tick();
        scl_out = 1'b0;
        tick();
    endtask
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic byte_rx(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask
endmodule // rfc_master_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the serial-bus register target.
// Assumes the master model beside it and a pull-up on SDA.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rfc_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic enable_pin = 1'b1;
    logic thermal = 1'b0;
    logic scl, sda_low, sda_oe, sda_o, fl_high, fl_tmo, fl_lim, r1_on, r2_on;
    logic [2:0] fl_level, r2_code;
    logic [3:0] r1_code;
    wire logic sda;
    int miscompares = 0;
    int tests_run = 0;
    logic [7:0] tbl [5] = '{8'h40, 8'h01, 8'h59, 8'h1a, 8'h7f};
    logic [7:0] bad [2] = '{8'h6c, 8'hf0};
    assign sda = ~sda_low & ~(sda_oe & ~sda_o);
    always #10 clk_sys = ~clk_sys;
    rfc_top #(.FLASH_MAX_CYC(50)) dut (
        .CLK_SYS_IN(clk_sys), .SRST_IN(srst), .ENABLE_PIN_IN(enable_pin),
        .THERMAL_SHDN_IN(thermal), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
        .SDA_OE_OUT(sda_oe), .FLASH_RANGE_HIGH_OUT(fl_high), .FLASH_LEVEL_OUT(fl_level),
        .FLASH_TMO_EN_OUT(fl_tmo), .FLASH_PULSE_LIMIT_OUT(fl_lim), .REG1_ON_OUT(r1_on),
        .REG1_CODE_OUT(r1_code), .REG2_ON_OUT(r2_on), .REG2_CODE_OUT(r2_code)
    );
    rfc_master_model m (.clk_in(clk_sys), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, r, d, output logic [2:0] k);
        m.start();
        m.byte_tx(a, k[2]);
        m.byte_tx(r, k[1]);
        m.byte_tx(d, k[0]);
        m.stop();
    endtask
    task automatic wchk(input logic [7:0] r, d);
        logic [2:0] k;
        wr(8'h6e, r, d, k);
        chk({5'h0, k}, 8'h07);
    endtask
    task automatic rchk(input logic [7:0] r, exp);
        logic [2:0] k;
        logic [7:0] d;
        m.start();
        m.byte_tx(8'h6e, k[2]);
        m.byte_tx(r, k[1]);
        m.start();
        m.byte_tx(8'h6f, k[0]);
        m.byte_rx(1'b1, d);
        m.stop();
        chk({5'h0, k}, 8'h07);
        chk(d, exp);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (99000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end
    initial begin
        logic [2:0] k;
        logic [7:0] d;
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk({7'h0, fl_tmo}, 8'h01);
        wchk(8'h00, 8'ha5);
        wchk(8'h01, 8'h5a);
        wchk(8'h02, 8'hff);
        wchk(8'h03, 8'hff);
        rchk(8'h00, 8'ha5);
        rchk(8'h02, 8'h1f);
        rchk(8'h03, 8'h7f);
        foreach (tbl[i]) begin
            wchk(8'h03, tbl[i]);
            chk({r1_on, 3'h0, r1_code},
                {tbl[i][3:0] != 4'h0 && tbl[i][3:0] <= 4'h9, 3'h0, tbl[i][3:0]});
            chk({r2_on, 4'h0, r2_code},
                {tbl[i][6:4] != 3'h0 && tbl[i][6:4] <= 3'h4, 4'h0, tbl[i][6:4]});
        end
        wchk(8'h02, 8'h0b);
        chk({fl_high, fl_level, fl_tmo, 3'h0}, 8'hd0);
        repeat (60) @(negedge clk_sys);
        chk({7'h0, fl_lim}, 8'h01);
        wchk(8'h02, 8'h0a);
        chk({4'h0, fl_high, fl_level}, 8'h05);
        thermal = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({5'h0, fl_level}, 8'h00);
        thermal = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({5'h0, fl_level}, 8'h05);
        m.start();
        m.byte_tx(8'h6e, k[2]);
        m.byte_tx(8'h00, k[1]);
        m.stop();
        foreach (bad[i]) begin
            wr(bad[i], 8'h00, 8'h33, k);
            chk({5'h0, k}, 8'h00);
        end
        m.start();
        m.byte_tx(8'h6f, k[0]);
        m.byte_rx(1'b1, d);
        m.stop();
        chk({7'h0, k[0]}, 8'h01);
        chk(d, 8'ha5);
        m.quarter = 125;
        wchk(8'h03, 8'h25);
        m.quarter = 31;
        chk({r1_code, 1'b0, r2_code}, 8'h52);
        enable_pin = 1'b0;
        repeat (5) @(negedge clk_sys);
        enable_pin = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk({r1_on, r1_code, fl_tmo, fl_high, r2_on}, 8'h04);
        rchk(8'h02, 8'h10);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
